// >>> boolean_word_ops_and_bit_shift_left.sv
// Execution datapath for boolean word operations and the multi-bit left shift
//
// Functional notes
// RULE_01 - AND word combines sources bitwise
// RULE_02 - OR word combines sources bitwise
// RULE_03 - XOR word: one where bits differ
// RULE_04 - Bit operand spans 16 or 32 points
// RULE_05 - Bit repeat advances 16 or 32 points
// RULE_06 - Word operand: one/two words, same stride
// RULE_07 - Repeat addresses count consecutive operands independently
// RULE_08 - Fixed destination keeps last cycle result
// RULE_09 - Repeated first source, fixed second source
// RULE_10 - Repeated destination receives one same result
// RULE_11 - Both sources repeat pairwise, last kept
// RULE_12 - First source and destination step together
// RULE_13 - All repeat: element k to k
// RULE_14 - Error sets sticky flag and indicator
// RULE_15 - Erroneous instruction writes no destination
// RULE_16 - Shift length 1-65535, amount 1-15
// RULE_17 - Shift toward MSB, carry last out
// RULE_18 - Vacated low bits take fill 0/1
// RULE_19 - Lower register holds the low word
// RULE_20 - Special relays refused as shift string
// RULE_21 - Program pulses input for single shift
// RULE_22 - Bit 15 feeds next word bit 0
`timescale 1ns/1ps
`default_nettype none

module boolean_word_ops_and_bit_shift_left #(
  parameter int unsigned REPEAT_LIMIT = 99
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                cmd_valid,
  input  wire bwsl_pkg::command_t  cmd,
  output logic                     cmd_ready,
  output logic                     done,
  output bwsl_pkg::mem_req_t       mem_req,
  input  wire logic [15:0]         mem_rd_data,
  input  wire logic                error_clear,
  output logic                     carry_flag,
  output logic                     exec_error_flag,
  output logic                     error_indicator
);

  // ****************************************************************
  // Parameter check and state encoding
  // ****************************************************************
  if (REPEAT_LIMIT < 1 || REPEAT_LIMIT > 127)
  begin : g_param_check
    $error("REPEAT_LIMIT out of range");
  end

  localparam logic [6:0] REPEAT_CAP = 7'(REPEAT_LIMIT);

  typedef enum logic [10:0] {
    st_idle   = 11'h001,
    st_check  = 11'h002,
    st_fetch  = 11'h004,
    st_fwait  = 11'h008,
    st_write  = 11'h010,
    st_sfill  = 11'h020,
    st_sfwait = 11'h040,
    st_sread  = 11'h080,
    st_srwait = 11'h100,
    st_done   = 11'h200
  } state_t;

  state_t              state;
  state_t              next_state;
  bwsl_pkg::command_t  cur;
  bwsl_pkg::command_t  next_cur;
  logic [6:0]          k;
  logic [6:0]          next_k;
  logic [1:0]          fidx;
  logic [1:0]          next_fidx;
  logic                half;
  logic                next_half;
  logic [31:0]         src1;
  logic [31:0]         next_src1;
  logic [31:0]         src2;
  logic [31:0]         next_src2;
  logic [15:0]         word_i;
  logic [15:0]         next_word_i;
  logic [15:0]         prev_word;
  logic [15:0]         next_prev_word;
  logic                fill;
  logic                next_fill;
  bwsl_pkg::mem_req_t  next_mem_req;
  logic                next_done;
  logic                next_carry;
  logic                next_error;

  // ****************************************************************
  // Command checks, all made before any write
  // ****************************************************************
  function automatic logic misaligned(input bwsl_pkg::operand_t o);
    misaligned = (o.kind == bwsl_pkg::kind_bit || o.kind == bwsl_pkg::kind_relay) && (o.value[3:0] != 4'h0);
  endfunction : misaligned

  wire logic        is_shift;
  wire logic        bool_error;
  wire logic        shift_error;
  wire logic        check_error;
  wire logic [16:0] relay_end;
  assign is_shift  = (cur.op == bwsl_pkg::bit_shift_left_op);
  assign relay_end = {1'b0, cur.first_source.value[15:0]} + {1'b0, cur.string_length};
  // Boolean: repeat range, writable and aligned operands
  assign bool_error = (cur.repeat_count > REPEAT_CAP)
                    || (cur.destination_operand.kind == bwsl_pkg::kind_const)
                    || (cur.destination_operand.kind == bwsl_pkg::kind_relay
                        && cur.destination_operand.value[15:0] >= bwsl_pkg::GENERAL_RELAY_POINTS)
                    || misaligned(cur.first_source) || misaligned(cur.second_source_or_fill)
                    || misaligned(cur.destination_operand);
  // Shift: length, amount, fill value, general relays only
  assign shift_error = (cur.string_length == 16'h0000)                                         // see RULE_16
                     || (cur.shift_amount == 4'h0) || (cur.shift_amount > bwsl_pkg::SHIFT_MAX) // see RULE_16
                     || (cur.first_source.kind == bwsl_pkg::kind_const) || misaligned(cur.first_source)
                     || (cur.first_source.kind == bwsl_pkg::kind_relay
                         && relay_end > {1'b0, bwsl_pkg::GENERAL_RELAY_POINTS})              // see RULE_20
                     || (cur.second_source_or_fill.kind == bwsl_pkg::kind_const
                         && cur.second_source_or_fill.value > 32'h0000_0001);                // see RULE_18
  assign check_error = is_shift ? shift_error : bool_error;

  // ****************************************************************
  // Boolean sequencing decode
  // ****************************************************************
  wire logic [6:0]         cycles_total;
  wire logic               last_cycle;
  wire logic               fetch_last;
  wire logic [1:0]         fidx_step;
  wire logic               sources_fixed;
  wire bwsl_pkg::operand_t fetch_op;
  wire logic               fetch_const;
  wire logic               do_store;
  wire logic [15:0]        fetch_word;
  wire logic [31:0]        result;
  assign cycles_total  = (cur.repeat_count == 7'h00) ? 7'h01 : cur.repeat_count;  // see RULE_07
  assign last_cycle    = (k == cycles_total - 7'h01);
  assign fidx_step     = cur.dword ? 2'h1 : 2'h2;
  assign fetch_last    = cur.dword ? (fidx == 2'h3) : (fidx == 2'h2);
  // Fixed sources: one result serves every destination
  assign sources_fixed = !cur.first_source.rep && !cur.second_source_or_fill.rep;  // see RULE_10
  assign fetch_op      = fidx[1] ? cur.second_source_or_fill : cur.first_source;
  assign fetch_const   = (fetch_op.kind == bwsl_pkg::kind_const);
  assign do_store      = (state == st_fetch && fetch_const) || (state == st_fwait);
  assign fetch_word    = (state == st_fwait) ? mem_rd_data : fidx[0] ? fetch_op.value[31:16] : fetch_op.value[15:0];

  word_logic_unit #(
    .WIDTH (32)
  ) u_logic (
    .op     (cur.op),
    .a      (src1),
    .b      (src2),
    .result (result)
  );

  // ****************************************************************
  // Address selection for the single memory port
  // ****************************************************************
  wire logic               shift_phase;
  wire bwsl_pkg::operand_t string_op;
  wire bwsl_pkg::operand_t sel_op;
  wire logic [15:0]        sel_index;
  wire logic               sel_half;
  wire logic [15:0]        op_addr;
  assign shift_phase = (state == st_sfill) || (state == st_sread) || (state == st_srwait);
  assign string_op   = '{kind: cur.first_source.kind, rep: 1'b1, value: cur.first_source.value};
  // Each boolean operand steps by its own repeat flag, the shift string always steps
  assign sel_op      = (state == st_write) ? cur.destination_operand :                // see RULE_08 see RULE_12
                       (state == st_sfill) ? cur.second_source_or_fill :
                       shift_phase         ? string_op : fetch_op;                    // see RULE_09 see RULE_11
  assign sel_index   = shift_phase ? word_i : {9'h000, k};                            // see RULE_13
  assign sel_half    = (state == st_write) ? half : shift_phase ? 1'b0 : fidx[0];

  operand_addr u_addr (
    .operand (sel_op),
    .stride2 (cur.dword && !shift_phase),
    .index   (sel_index),
    .half    (sel_half),
    .addr    (op_addr)
  );

  // ****************************************************************
  // Left shift word step
  // ****************************************************************
  wire logic [16:0] word_count;
  wire logic [15:0] last_word;
  wire logic [15:0] low_in;
  wire logic [31:0] shifted_full;
  wire logic [15:0] top_mask;
  wire logic [15:0] new_word;
  wire logic [16:0] carry_pos;
  wire logic        carry_in_fill;
  wire logic        carry_here;
  assign word_count    = ({1'b0, cur.string_length} + {12'h000, bwsl_pkg::WORD_ROUND}) >> 4;
  assign last_word     = word_count[15:0] - 16'h0001;
  // Lowest word takes fill, others the original word below
  assign low_in        = (word_i == 16'h0000) ? {16{fill}} : prev_word;              // see RULE_18
  assign shifted_full  = {mem_rd_data, low_in} << cur.shift_amount;                   // see RULE_22
  assign top_mask      = (word_i == last_word && cur.string_length[3:0] != 4'h0) ?
                         ((16'h0001 << cur.string_length[3:0]) - 16'h0001) : bwsl_pkg::WORD_ONES;
  // Bits above the string end stay untouched
  assign new_word      = (shifted_full[31:16] & top_mask) | (mem_rd_data & ~top_mask);  // see RULE_17
  assign carry_pos     = {1'b0, cur.string_length} - {13'h0000, cur.shift_amount};
  assign carry_in_fill = carry_pos[16];
  assign carry_here    = !carry_in_fill && (word_i == carry_pos[15:0] >> 4);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    next_state     = state;
    next_cur       = cur;
    next_k         = k;
    next_fidx      = fidx;
    next_half      = half;
    next_src1      = src1;
    next_src2      = src2;
    next_word_i    = word_i;
    next_prev_word = prev_word;
    next_fill      = fill;
    next_mem_req   = '0;
    next_done      = 1'b0;
    next_carry     = carry_flag;
    next_error     = error_clear ? 1'b0 : exec_error_flag;
    case (state)
      st_idle:
        if (cmd_valid && cmd_ready)
        begin
          next_cur   = cmd;
          next_state = st_check;
        end
      st_check:
        if (check_error)
        begin
          next_error = 1'b1;  // see RULE_14
          next_state = st_done;  // see RULE_15
        end
        else if (is_shift)
        begin
          next_word_i = 16'h0000;
          next_fill   = cur.second_source_or_fill.value[0];
          next_state  = (cur.second_source_or_fill.kind == bwsl_pkg::kind_const) ? st_sread : st_sfill;
        end
        else
        begin
          next_k     = 7'h00;
          next_fidx  = 2'h0;
          next_state = st_fetch;
        end
      st_fetch:
        if (!fetch_const)
        begin
          next_mem_req.rd_en = 1'b1;
          next_mem_req.addr  = op_addr;
          next_state         = st_fwait;
        end
      st_write:
      begin
        next_mem_req.wr_en   = 1'b1;
        next_mem_req.addr    = op_addr;
        next_mem_req.wr_data = half ? result[31:16] : result[15:0];  // see RULE_19
        if (cur.dword && !half)
          next_half = 1'b1;
        else if (last_cycle)
          next_state = st_done;
        else
        begin
          next_k     = k + 7'h01;
          next_fidx  = 2'h0;
          next_half  = 1'b0;
          next_state = sources_fixed ? st_write : st_fetch;  // see RULE_10
        end
      end
      st_sfill:
      begin
        next_mem_req.rd_en = 1'b1;
        next_mem_req.addr  = op_addr;
        next_state         = st_sfwait;
      end
      st_sfwait:
      begin
        next_fill  = mem_rd_data[cur.second_source_or_fill.value[3:0]];  // see RULE_18
        next_state = st_sread;
      end
      st_sread:
      begin
        next_mem_req.rd_en = 1'b1;
        next_mem_req.addr  = op_addr;
        next_state         = st_srwait;
      end
      st_srwait:
      begin
        next_mem_req.wr_en   = 1'b1;
        next_mem_req.addr    = op_addr;
        next_mem_req.wr_data = new_word;
        next_prev_word       = mem_rd_data;
        if (carry_here)
          next_carry = mem_rd_data[carry_pos[3:0]];  // see RULE_17
        else if (carry_in_fill && word_i == 16'h0000)
          next_carry = fill;
        next_word_i = word_i + 16'h0001;
        next_state  = (word_i == last_word) ? st_done : st_sread;  // see RULE_16
      end
      st_done:
      begin
        next_done  = 1'b1;
        next_state = st_idle;
      end
      default:
        next_state = st_idle;
    endcase
    // Operand word capture and fetch advance
    if (do_store)
    begin
      case (fidx)
        2'h0:    next_src1[15:0]  = fetch_word;
        2'h1:    next_src1[31:16] = fetch_word;
        2'h2:    next_src2[15:0]  = fetch_word;
        default: next_src2[31:16] = fetch_word;
      endcase
      if (!cur.dword)
      begin
        next_src1[31:16] = (fidx == 2'h0) ? 16'h0000 : next_src1[31:16];
        next_src2[31:16] = (fidx == 2'h2) ? 16'h0000 : next_src2[31:16];
      end
      next_fidx  = fidx + fidx_step;
      next_half  = 1'b0;
      next_state = fetch_last ? st_write : st_fetch;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state           <= st_idle;
      cur             <= '0;
      k               <= 7'h00;
      fidx            <= 2'h0;
      half            <= 1'b0;
      src1            <= 32'h0000_0000;
      src2            <= 32'h0000_0000;
      word_i          <= 16'h0000;
      prev_word       <= 16'h0000;
      fill            <= 1'b0;
      mem_req         <= '0;
      done            <= 1'b0;
      cmd_ready       <= 1'b0;
      carry_flag      <= bwsl_pkg::FLAG_RESET;
      exec_error_flag <= bwsl_pkg::FLAG_RESET;
      error_indicator <= bwsl_pkg::FLAG_RESET;
    end
    else
    begin
      state           <= next_state;
      cur             <= next_cur;
      k               <= next_k;
      fidx            <= next_fidx;
      half            <= next_half;
      src1            <= next_src1;
      src2            <= next_src2;
      word_i          <= next_word_i;
      prev_word       <= next_prev_word;
      fill            <= next_fill;
      mem_req         <= next_mem_req;
      done            <= next_done;
      cmd_ready       <= (next_state == st_idle);  // Re-issued each scan by the engine, see RULE_21
      carry_flag      <= next_carry;
      exec_error_flag <= next_error;  // see RULE_14
      error_indicator <= next_error;  // see RULE_14
    end
  end

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [15:0] first_wr_addr;
  logic        wr_seen;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      first_wr_addr <= 16'h0000;
      wr_seen       <= 1'b0;
    end
    else if (state == st_check)
      wr_seen <= 1'b0;
    else if (mem_req.wr_en && !wr_seen)
    begin
      first_wr_addr <= mem_req.addr;
      wr_seen       <= 1'b1;
    end
  end

  a_and_result: assert property (state == st_write && !half && cur.op == bwsl_pkg::and_word_op
    |=> mem_req.wr_data == ($past(src1[15:0]) & $past(src2[15:0]))) else $error("and result wrong"); // see RULE_01
  a_or_result: assert property (state == st_write && !half && cur.op == bwsl_pkg::or_word_op
    |=> mem_req.wr_data == ($past(src1[15:0]) | $past(src2[15:0]))) else $error("or result wrong"); // see RULE_02
  a_xor_result: assert property (state == st_write && !half && cur.op == bwsl_pkg::xor_word_op
    |=> mem_req.wr_data == ($past(src1[15:0]) ^ $past(src2[15:0]))) else $error("xor result wrong"); // see RULE_03
  a_error_no_write: assert property (state == st_check && check_error
    |=> !mem_req.wr_en ##1 (!mem_req.wr_en && done)) else $error("write after error"); // see RULE_15
  a_error_sets_flag: assert property (state == st_check && check_error && !error_clear
    |=> exec_error_flag && error_indicator) else $error("error flag not set"); // see RULE_14
  a_error_sticky: assert property (exec_error_flag && !error_clear
    |=> exec_error_flag && error_indicator) else $error("error flag dropped"); // see RULE_14
  a_fixed_dest: assert property (mem_req.wr_en && wr_seen && !is_shift && !cur.dword
    && !cur.destination_operand.rep |-> mem_req.addr == first_wr_addr) else $error("fixed dest moved"); // see RULE_08
  a_fill_low: assert property (state == st_srwait && word_i == 16'h0000
    |-> ((new_word ^ {16{fill}}) & ((16'h0001 << cur.shift_amount) - 16'h0001) & top_mask) == 16'h0000)
    else $error("fill bits wrong"); // see RULE_18
  a_shift_bounds: assert property (state == st_srwait |-> cur.shift_amount inside {[4'h1:4'hF]}
    && cur.string_length != 16'h0000) else $error("shift operands out of range"); // see RULE_16

  c_dword_repeat: cover property (state == st_write && cur.dword && cur.destination_operand.rep && k == 7'h02);
  c_shift_carry:  cover property (state == st_srwait && carry_here ##1 carry_flag);
  c_error_seen:   cover property (state == st_check && check_error);
  c_multi_word:   cover property (state == st_srwait && word_i == 16'h0002);

endmodule : boolean_word_ops_and_bit_shift_left

`default_nettype wire

// >>> bwsl_pkg.sv
// Constants and carrier types shared by the boolean word and left shift datapath
package bwsl_pkg;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [6:0]  REPEAT_MAX           = 7'h63;    // Largest repeat count (99)
  localparam logic [3:0]  SHIFT_MAX            = 4'hF;     // Largest shift amount (15)
  localparam logic [15:0] GENERAL_RELAY_POINTS = 16'h0800; // General relays, 2048 points
  localparam logic [15:0] BIT_AREA_BASE        = 16'hE000; // Word address of I/Q/R bit area
  localparam logic [15:0] RELAY_AREA_BASE      = 16'hF000; // Word address of relay area
  localparam logic [15:0] WORD_ONES            = 16'hFFFF; // All bits of one word
  localparam logic [4:0]  WORD_ROUND           = 5'h0F;    // Rounds a bit count up to words
  localparam logic        FLAG_RESET           = 1'b0;     // Reset value of all flags

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    kind_word  = 2'h0,
    kind_bit   = 2'h1,
    kind_relay = 2'h2,
    kind_const = 2'h3
  } operand_kind_t;

  typedef enum logic [1:0] {
    and_word_op       = 2'h0,
    or_word_op        = 2'h1,
    xor_word_op       = 2'h2,
    bit_shift_left_op = 2'h3
  } opcode_t;

  typedef struct packed {
    operand_kind_t kind;
    logic          rep;
    logic [31:0]   value;
  } operand_t;

  typedef struct packed {
    opcode_t     op;
    logic        dword;
    operand_t    first_source;
    operand_t    second_source_or_fill;
    operand_t    destination_operand;
    logic [6:0]  repeat_count;
    logic [15:0] string_length;
    logic [3:0]  shift_amount;
  } command_t;

  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [15:0] wr_data;
  } mem_req_t;

endpackage : bwsl_pkg

// >>> word_logic_unit.sv
// Bitwise AND, OR and exclusive OR of two operand words
`timescale 1ns/1ps
`default_nettype none

module word_logic_unit #(
  parameter int unsigned WIDTH = 32
) (
  input  wire bwsl_pkg::opcode_t op,
  input  wire logic [WIDTH-1:0]  a,
  input  wire logic [WIDTH-1:0]  b,
  output logic [WIDTH-1:0]       result
);

  // Refuse a width the datapath cannot hold
  if (WIDTH < 16 || WIDTH > 32)
  begin : g_width_check
    $error("word_logic_unit WIDTH out of range");
  end

  // Per-bit combination
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    assign result[i] = (op == bwsl_pkg::and_word_op) ? (a[i] & b[i]) :  // see RULE_01
                       (op == bwsl_pkg::or_word_op)  ? (a[i] | b[i]) :  // see RULE_02
                                                       (a[i] ^ b[i]);   // see RULE_03
  end

endmodule : word_logic_unit

`default_nettype wire

// >>> operand_addr.sv
// Word address of one operand element, by kind, repeat index and half
`timescale 1ns/1ps
`default_nettype none

module operand_addr (
  input  wire bwsl_pkg::operand_t operand,
  input  wire logic               stride2,
  input  wire logic [15:0]        index,
  input  wire logic               half,
  output logic [15:0]             addr
);

  logic [15:0] base;
  logic [15:0] step;

  // Bit kinds address 16 points per word
  assign base = (operand.kind == bwsl_pkg::kind_bit)   ? bwsl_pkg::BIT_AREA_BASE + {4'h0, operand.value[15:4]} :
                (operand.kind == bwsl_pkg::kind_relay) ? bwsl_pkg::RELAY_AREA_BASE + {4'h0, operand.value[15:4]} :
                                                         operand.value[15:0];
  // Advance 16/32 points or 1/2 words per repeat
  assign step = !operand.rep ? 16'h0000 : stride2 ? {index[14:0], 1'b0} : index;  // see RULE_05 see RULE_06
  assign addr = base + step + {15'h0000, half};  // see RULE_04 see RULE_19

endmodule : operand_addr

`default_nettype wire

// >>> boolean_word_ops_and_bit_shift_left_tb_top.sv
// Self-checking bench for the boolean word and left shift datapath
`timescale 1ns/1ps
`default_nettype none
module boolean_word_ops_and_bit_shift_left_tb_top;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               cmd_valid = 1'b0;
  bwsl_pkg::command_t cmd = '0;
  logic               error_clear = 1'b0;
  logic               cmd_ready, done, carry_flag, exec_error_flag, error_indicator;
  bwsl_pkg::mem_req_t mem_req;
  logic [15:0]        mem_rd_data;
  logic [15:0]        mem [0:65535];
  int                 n_errors = 0;
  int                 tests_run = 0;
  // ****************************************************************
  // Clock, memory and design
  // ****************************************************************
  always #10 clock = ~clock;
  assign mem_rd_data = mem[mem_req.addr];
  // Memory takes a write at the edge ending its request cycle
  always @(posedge clock) if (mem_req.wr_en === 1'b1) mem[mem_req.addr] <= mem_req.wr_data;
  boolean_word_ops_and_bit_shift_left u_boolean_word_ops_and_bit_shift_left (
    .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .done(done), .mem_req(mem_req), .mem_rd_data(mem_rd_data), .error_clear(error_clear),
    .carry_flag(carry_flag), .exec_error_flag(exec_error_flag), .error_indicator(error_indicator));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic end_of_test;
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic bwsl_pkg::operand_t opw(input logic r, input logic [31:0] v,
                                             input bwsl_pkg::operand_kind_t k = bwsl_pkg::kind_word);
    return '{kind: k, rep: r, value: v};
  endfunction : opw
  function automatic logic [15:0] calc(input int o, input logic [15:0] a, input logic [15:0] b);
    return (o == 0) ? (a & b) : (o == 1) ? (a | b) : (a ^ b);
  endfunction : calc
  // Offers one command and waits, bounded, for its take and its done pulse
  task automatic run(input int o, input logic dw, input bwsl_pkg::operand_t a, input bwsl_pkg::operand_t b,
                     input bwsl_pkg::operand_t d, input logic [6:0] n, input logic [15:0] len = 16'h0000,
                     input logic [3:0] amt = 4'h0);
    int i;
    i = 0;
    cmd <= '{bwsl_pkg::opcode_t'(o), dw, a, b, d, n, len, amt};
    cmd_valid <= 1'b1;
    do @(posedge clock); while (cmd_ready !== 1'b1 && ++i < 50);
    cmd_valid <= 1'b0;
    do @(posedge clock); while (done !== 1'b1 && ++i < 600);
    if (i >= 600)
    begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask : run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_logic;
    mem[10] = 16'hC3A5;
    mem[20] = 16'h0FF0;
    for (int o = 0; o < 3; o++)
    begin
      run(o, 1'b0, opw(0, 10), opw(0, 20), opw(0, 30), 7'h00);
      check(mem[30], calc(o, 16'hC3A5, 16'h0FF0));
    end
  endtask : t_logic
  task automatic t_repeat_all;
    for (int k = 0; k < 4; k++) mem[10 + k] = 16'h1234 << k;
    for (int k = 0; k < 3; k++) mem[20 + k] = 16'hFF00 >> k;
    run(2, 1'b0, opw(1, 10), opw(1, 20), opw(1, 30), 7'h03);
    for (int k = 0; k < 3; k++) check(mem[30 + k], (16'h1234 << k) ^ (16'hFF00 >> k));
    run(0, 1'b0, opw(1, 10), opw(1, 20), opw(0, 40), 7'h03);
    check(mem[40], mem[12] & mem[22]);
    run(1, 1'b0, opw(1, 10), opw(0, 20), opw(0, 41), 7'h03);
    check(mem[41], mem[12] | mem[20]);
    run(1, 1'b1, opw(1, 10), opw(0, 20), opw(1, 50), 7'h02);
    check({mem[51], mem[50]}, {mem[11] | mem[21], mem[10] | mem[20]});
    check({mem[53], mem[52]}, {mem[13] | mem[21], mem[12] | mem[20]});
  endtask : t_repeat_all
  task automatic t_dest_rep;
    run(0, 1'b1, opw(0, 10), opw(0, 20), opw(1, 60), 7'h03);
    for (int k = 0; k < 6; k += 2)
      check({mem[61 + k], mem[60 + k]}, {mem[11] & mem[21], mem[10] & mem[20]});
  endtask : t_dest_rep
  task automatic t_error;
    mem[16'hF100] = 16'h5555;
    run(0, 1'b0, opw(0, 10), opw(0, 20), opw(0, 32'h1000, bwsl_pkg::kind_relay), 7'h00);
    check(mem[16'hF100], 16'h5555);
    check({exec_error_flag, error_indicator}, 2'h3);
    run(0, 1'b0, opw(0, 10), opw(0, 20), opw(0, 70), 7'h00);
    check({exec_error_flag, error_indicator, mem[70]}, {2'h3, mem[10] & mem[20]});
    error_clear <= 1'b1;
    @(posedge clock);
    error_clear <= 1'b0;
    repeat (2) @(posedge clock);
    check({exec_error_flag, error_indicator}, 2'h0);
  endtask : t_error
  task automatic t_shift;
    mem[80] = 16'h0000;
    mem[81] = 16'hFFFF;
    run(3, 1'b0, opw(0, 80), opw(0, 1, bwsl_pkg::kind_const), opw(0, 0), 7'h00, 16'h0020, 4'h2);
    check({carry_flag, mem[81], mem[80]}, {1'b1, 16'hFFFC, 16'h0003});
    mem[82] = 16'hAAAA;
    run(3, 1'b0, opw(0, 82), opw(0, 0, bwsl_pkg::kind_const), opw(0, 0), 7'h00, 16'h0010, 4'h1);
    check({carry_flag, mem[82]}, {1'b1, 16'h5554});
    run(3, 1'b0, opw(0, 82), opw(0, 0, bwsl_pkg::kind_const), opw(0, 0), 7'h00, 16'h0010, 4'hF);
    check({carry_flag, mem[82], exec_error_flag}, {1'b0, 16'h0000, 1'b0});
    mem[16'hE001] = 16'h0008;
    mem[16'hF002] = 16'h1234;
    run(3, 1'b0, opw(0, 32'h20, bwsl_pkg::kind_relay), opw(0, 32'h13, bwsl_pkg::kind_bit), opw(0, 0), 7'h00,
        16'h000C, 4'h3);
    check({carry_flag, mem[16'hF002]}, {1'b1, 16'h11A7});
    run(3, 1'b0, opw(0, 82), opw(0, 0, bwsl_pkg::kind_const), opw(0, 0), 7'h00, 16'h0000, 4'h1);
    check(exec_error_flag, 1'b1);
  endtask : t_shift
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_logic();
    t_repeat_all();
    t_dest_rep();
    t_error();
    t_shift();
    end_of_test();
  end
endmodule : boolean_word_ops_and_bit_shift_left_tb_top
`default_nettype wire
